/* File: drive_status_fault_response_regs.sv */
// servo drive status words and fault response parameter bank
`timescale 1ns/1ps
module drive_status_fault_response_regs #(
  parameter int SPEED_W = 16,
  parameter int POS_W   = 32
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // parameter access port
  input  wire logic [15:0] regAddr,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [15:0] regWdata,
  output logic      [15:0] regRdata,
  output logic             regAck,
  output logic             regErr,
  // housekeeping
  input  wire logic        faultClearCmd,
  input  wire logic [1:0]  controlMode,
  // warning causes
  input  wire logic        generalWarn,
  input  wire logic [15:0] generalWarnCode,
  input  wire logic        ampTempHigh,
  input  wire logic        motorTempHigh,
  input  wire logic        ampOverload,
  input  wire logic        motorOverload,
  input  wire logic        brakeOverload,
  input  wire logic        canWarn,
  input  wire logic        encoderWarn,
  input  wire logic        rs485Warn,
  input  wire logic        fieldbusWarn,
  input  wire logic        dcUndervoltage,
  input  wire logic        phaseFault,
  input  wire logic        positionInvalid,
  input  wire logic        powerRemovalInputA_b,
  input  wire logic        powerRemovalInputB_b,
  // fault events
  input  wire logic        trackingErrorEvent,
  input  wire logic        phaseLossEvent,
  input  wire logic        faultEvent,
  input  wire logic [2:0]  faultClass,
  input  wire logic [15:0] faultNumber,
  // motion inputs
  input  wire logic signed [SPEED_W-1:0] actualSpeed,
  input  wire logic signed [SPEED_W-1:0] setpointSpeed,
  input  wire logic signed [POS_W-1:0]   positionDeviation,
  input  wire logic        [POS_W-1:0]   positionWindow,
  // status out
  output logic      [15:0] latchedWarnings,
  output logic      [15:0] actionWord,
  output logic      [15:0] lastStopFaultNumber,
  output logic      [15:0] lastWarningCode,
  output logic      [1:0]  reactionClass,
  output logic             reactionStrobe
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (SPEED_W < 5 || POS_W < 2) begin : g_chk
    $error("drive status bank widths too small");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] phaseLossResp;
    logic [15:0] trackResp;
    logic [15:0] warn;
    logic [15:0] action;
    logic [4:0]  classPresent;
    logic [15:0] last_stop_fault_number;
    logic [15:0] lastWarnCode;
    logic [15:0] rdata;
    logic        ack;
    logic        err;
    logic [1:0]  reactClass;
    logic        reactStrobe;
  } dsf_bank_t;

  dsf_bank_t state_reg;
  dsf_bank_t state_next;

  // ----------------------------------------------------------------
  // pin synchroniser and motion flags
  // ----------------------------------------------------------------
  logic [1:0] pwrRemSync_b;
  logic       driveStopped;
  logic       rotatePositive;
  logic       rotateNegative;
  logic       inPositionWindow;
  logic       pgStopped;
  logic       pgDecel;
  logic       pgAccel;
  logic       pgConstant;

  // power removal pins idle high, so reset the stages high
  dsf_sync #(
    .W       (2),
    .RST_VAL (2'h3)
  ) u_pin_sync (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .asyncIn ({powerRemovalInputB_b, powerRemovalInputA_b}),
    .syncOut (pwrRemSync_b)
  );

  dsf_motion_state #(
    .SPEED_W (SPEED_W),
    .POS_W   (POS_W)
  ) u_motion (
    .mclk              (mclk),
    .rst_b             (rst_b),
    .actualSpeed       (actualSpeed),
    .setpointSpeed     (setpointSpeed),
    .positionDeviation (positionDeviation),
    .positionWindow    (positionWindow),
    .driveStopped      (driveStopped),
    .rotatePositive    (rotatePositive),
    .rotateNegative    (rotateNegative),
    .inPositionWindow  (inPositionWindow),
    .pgStopped         (pgStopped),
    .pgDecel           (pgDecel),
    .pgAccel           (pgAccel),
    .pgConstant        (pgConstant)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // a response setting outside 1..3 is refused, old value kept
  function automatic logic classLegal(input logic [15:0] v);
    classLegal = (v >= dsf_pkg::RESP_CLASS_MIN) && (v <= dsf_pkg::RESP_CLASS_MAX);
  endfunction : classLegal

  // bus warnings mean nothing unless the bus is in control
  function automatic logic [15:0] modeMask(input logic [1:0] mode);
    modeMask = (mode == dsf_pkg::CTRL_FIELDBUS) ? 16'hFFFF : ~dsf_pkg::WARN_BUS_MASK;
  endfunction : modeMask

  // ----------------------------------------------------------------
  // combinational next state
  // ----------------------------------------------------------------
  logic [15:0] warnCause;
  logic [15:0] warnLatchPart;
  logic [4:0]  classSet;
  logic [15:0] actionNext;

  always_comb begin
    state_next             = state_reg;
    state_next.ack         = 1'b0;
    state_next.err         = 1'b0;
    state_next.reactStrobe = 1'b0;
    warnCause              = '0;
    classSet               = '0;
    actionNext             = '0;

    warnCause[dsf_pkg::WB_GENERAL]     = generalWarn;
    warnCause[dsf_pkg::WB_AMP_TEMP]    = ampTempHigh;
    warnCause[dsf_pkg::WB_MOTOR_TEMP]  = motorTempHigh;
    warnCause[dsf_pkg::WB_AMP_I2T]     = ampOverload;
    warnCause[dsf_pkg::WB_MOTOR_I2T]   = motorOverload;
    warnCause[dsf_pkg::WB_BRAKE_I2T]   = brakeOverload;
    warnCause[dsf_pkg::WB_CAN]         = canWarn;
    warnCause[dsf_pkg::WB_ENCODER]     = encoderWarn;
    warnCause[dsf_pkg::WB_RS485]       = rs485Warn;
    warnCause[dsf_pkg::WB_FIELDBUS]    = fieldbusWarn;
    warnCause[dsf_pkg::WB_PWR_REMOVAL] = !pwrRemSync_b[0] || !pwrRemSync_b[1];
    warnCause[dsf_pkg::WB_UNDERVOLT]   = dcUndervoltage || phaseFault;
    warnCause[dsf_pkg::WB_POS_INVALID] = positionInvalid;

    warnCause = warnCause & modeMask(controlMode);

    warnLatchPart = faultClearCmd ? 16'h0000 : state_reg.warn;
    warnLatchPart = (warnLatchPart | warnCause) & ~dsf_pkg::WARN_AUTO_MASK;
    state_next.warn = (warnLatchPart | (warnCause & dsf_pkg::WARN_AUTO_MASK))
                      & ~dsf_pkg::WARN_RSVD_MASK;

    // detail of the general warning, newest wins
    if (generalWarn) begin
      state_next.lastWarnCode = generalWarnCode;
    end

    if (trackingErrorEvent) begin
      classSet[state_reg.trackResp[2:0]] = 1'b1;
    end
    if (phaseLossEvent) begin
      classSet[state_reg.phaseLossResp[2:0]] = 1'b1;
    end
    if (faultEvent && (faultClass < 3'(dsf_pkg::NUM_CLASSES))) begin
      classSet[faultClass] = 1'b1;
    end

    // report the harder of two simultaneous reactions
    if (trackingErrorEvent || phaseLossEvent) begin
      state_next.reactStrobe = 1'b1;
      if (trackingErrorEvent && phaseLossEvent) begin
        state_next.reactClass = (state_reg.trackResp[1:0] > state_reg.phaseLossResp[1:0])
                                ? state_reg.trackResp[1:0] : state_reg.phaseLossResp[1:0];
      end else if (trackingErrorEvent) begin
        state_next.reactClass = state_reg.trackResp[1:0];
      end else begin
        state_next.reactClass = state_reg.phaseLossResp[1:0];
      end
    end

    if (trackingErrorEvent) begin
      state_next.last_stop_fault_number = dsf_pkg::FAULT_NUM_TRACKING;
    end else if (phaseLossEvent) begin
      state_next.last_stop_fault_number = dsf_pkg::FAULT_NUM_PHASELOSS;
    end else if (faultEvent && (faultClass != 3'h0)) begin
      state_next.last_stop_fault_number = faultNumber;
    end

    state_next.classPresent = (faultClearCmd ? 5'h00 : state_reg.classPresent) | classSet;

    // action word assembly, gaps stay zero
    // class bits 0 to 4
    actionNext[dsf_pkg::AB_CLASS0 +: dsf_pkg::NUM_CLASSES] = state_reg.classPresent;
    actionNext[dsf_pkg::AB_STOPPED]    = driveStopped;
    actionNext[dsf_pkg::AB_POS_DIR]    = rotatePositive;
    actionNext[dsf_pkg::AB_NEG_DIR]    = rotateNegative;
    actionNext[dsf_pkg::AB_IN_WINDOW]  = inPositionWindow;
    actionNext[dsf_pkg::AB_PG_STOPPED] = pgStopped;
    actionNext[dsf_pkg::AB_PG_DECEL]   = pgDecel;
    actionNext[dsf_pkg::AB_PG_ACCEL]   = pgAccel;
    actionNext[dsf_pkg::AB_PG_CONST]   = pgConstant;
    state_next.action = actionNext;

    // ----------------------------------------------------------------
    // parameter access, a write beats a read in the same cycle
    // ----------------------------------------------------------------
    if (regWrite) begin
      unique case (regAddr)
        dsf_pkg::ADDR_PHASE_LOSS_RESP: begin
          if (classLegal(regWdata)) begin
            state_next.phaseLossResp = regWdata;
            state_next.ack           = 1'b1;
          end else begin
            state_next.err = 1'b1;
          end
        end
        dsf_pkg::ADDR_TRACK_RESP: begin
          if (classLegal(regWdata)) begin
            state_next.trackResp = regWdata;
            state_next.ack       = 1'b1;
          end else begin
            state_next.err = 1'b1;
          end
        end
        default: begin
          state_next.err = 1'b1;
        end
      endcase
    end else if (regRead) begin
      state_next.ack = 1'b1;
      unique case (regAddr)
        dsf_pkg::ADDR_PHASE_LOSS_RESP: state_next.rdata = state_reg.phaseLossResp;
        dsf_pkg::ADDR_TRACK_RESP:      state_next.rdata = state_reg.trackResp;
        dsf_pkg::ADDR_ACTION_WORD:     state_next.rdata = state_reg.action;
        dsf_pkg::ADDR_STOP_FAULT:      state_next.rdata = state_reg.last_stop_fault_number;
        dsf_pkg::ADDR_LATCHED_WARN:    state_next.rdata = state_reg.warn;
        default: begin
          state_next.rdata = 16'h0000;
          state_next.ack   = 1'b0;
          state_next.err   = 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_reg               <= '0;
      state_reg.trackResp     <= dsf_pkg::RST_TRACK_RESP;
      state_reg.phaseLossResp <= dsf_pkg::RST_PHASE_LOSS_RESP;
      state_reg.warn          <= dsf_pkg::RST_WORD;
      state_reg.action        <= dsf_pkg::RST_WORD;
      state_reg.last_stop_fault_number     <= dsf_pkg::RST_WORD;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign regRdata            = state_reg.rdata;
  assign regAck              = state_reg.ack;
  assign regErr              = state_reg.err;
  assign latchedWarnings     = state_reg.warn;
  assign actionWord          = state_reg.action;
  assign lastStopFaultNumber = state_reg.last_stop_fault_number;
  assign lastWarningCode     = state_reg.lastWarnCode;
  assign reactionClass       = state_reg.reactClass;
  assign reactionStrobe      = state_reg.reactStrobe;

endmodule : drive_status_fault_response_regs

/* File: dsf_pkg.sv */
// shared constants for the drive status and fault response bank
package dsf_pkg;

  // ----------------------------------------------------------------
  // parameter addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_PHASE_LOSS_RESP = 16'h0514;
  localparam logic [15:0] ADDR_TRACK_RESP      = 16'h0516;
  localparam logic [15:0] ADDR_ACTION_WORD     = 16'h1C08;
  localparam logic [15:0] ADDR_STOP_FAULT      = 16'h1C0A;
  localparam logic [15:0] ADDR_LATCHED_WARN    = 16'h1C18;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_PHASE_LOSS_RESP = 16'h0002;
  localparam logic [15:0] RST_TRACK_RESP      = 16'h0003;
  localparam logic [15:0] RST_WORD            = 16'h0000;

  // legal range of an error class response setting
  localparam logic [15:0] RESP_CLASS_MIN = 16'h0001;
  localparam logic [15:0] RESP_CLASS_MAX = 16'h0003;

  // ----------------------------------------------------------------
  // warning word bit positions
  // ----------------------------------------------------------------
  localparam int WB_GENERAL     = 0;
  localparam int WB_AMP_TEMP    = 1;
  localparam int WB_MOTOR_TEMP  = 2;
  localparam int WB_AMP_I2T     = 4;
  localparam int WB_MOTOR_I2T   = 5;
  localparam int WB_BRAKE_I2T   = 6;
  localparam int WB_CAN         = 7;
  localparam int WB_ENCODER     = 8;
  localparam int WB_RS485       = 9;
  localparam int WB_PWR_REMOVAL = 10;
  localparam int WB_UNDERVOLT   = 11;
  localparam int WB_FIELDBUS    = 12;
  localparam int WB_POS_INVALID = 13;
  // bits that follow their cause instead of latching
  localparam logic [15:0] WARN_AUTO_MASK = 16'h2C00;
  // reserved bits 3, 14 and 15
  localparam logic [15:0] WARN_RSVD_MASK = 16'hC008;
  // bus-related warnings, only meaningful under fieldbus control
  localparam logic [15:0] WARN_BUS_MASK  = 16'h1080;

  // ----------------------------------------------------------------
  // action word bit positions
  // ----------------------------------------------------------------
  localparam int AB_CLASS0     = 0;
  localparam int AB_STOPPED    = 6;
  localparam int AB_POS_DIR    = 7;
  localparam int AB_NEG_DIR    = 8;
  localparam int AB_IN_WINDOW  = 9;
  localparam int AB_PG_STOPPED = 11;
  localparam int AB_PG_DECEL   = 12;
  localparam int AB_PG_ACCEL   = 13;
  localparam int AB_PG_CONST   = 14;
  localparam int NUM_CLASSES   = 5;

  // speed below which the drive counts as stopped, in rpm
  localparam int unsigned STOP_SPEED_RPM = 9;

  // ----------------------------------------------------------------
  // control modes and internal fault numbers
  // ----------------------------------------------------------------
  localparam logic [1:0] CTRL_LOCAL    = 2'h0;
  localparam logic [1:0] CTRL_IO       = 2'h1;
  localparam logic [1:0] CTRL_FIELDBUS = 2'h2;
  localparam logic [15:0] FAULT_NUM_TRACKING  = 16'h0001;
  localparam logic [15:0] FAULT_NUM_PHASELOSS = 16'h0002;

endpackage : dsf_pkg

/* File: dsf_sync.sv */
// two-stage synchroniser for pins entering the mclk domain
`timescale 1ns/1ps
module dsf_sync #(
  parameter int              W       = 2,
  parameter logic [W-1:0]    RST_VAL = '1
) (
  input  wire logic         mclk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  if (W < 1) begin : g_chk
    $error("dsf_sync width must be at least one");
  end

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } dsf_sync_t;

  dsf_sync_t state_reg;
  dsf_sync_t state_next;

  // first stage feeds only the second stage
  always_comb begin
    state_next        = state_reg;
    state_next.stage1 = asyncIn;
    state_next.stage2 = state_reg.stage1;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_reg <= '{stage1: RST_VAL, stage2: RST_VAL};
    end else begin
      state_reg <= state_next;
    end
  end

  assign syncOut = state_reg.stage2;

endmodule : dsf_sync

/* File: dsf_motion_state.sv */
// motion and profile generator state flags for the action word
`timescale 1ns/1ps
module dsf_motion_state #(
  parameter int SPEED_W = 16,
  parameter int POS_W   = 32
) (
  input  wire logic               mclk,
  input  wire logic               rst_b,
  input  wire logic signed [SPEED_W-1:0] actualSpeed,
  input  wire logic signed [SPEED_W-1:0] setpointSpeed,
  input  wire logic signed [POS_W-1:0]   positionDeviation,
  input  wire logic        [POS_W-1:0]   positionWindow,
  output logic                    driveStopped,
  output logic                    rotatePositive,
  output logic                    rotateNegative,
  output logic                    inPositionWindow,
  output logic                    pgStopped,
  output logic                    pgDecel,
  output logic                    pgAccel,
  output logic                    pgConstant
);

  if (SPEED_W < 5 || POS_W < 2) begin : g_chk
    $error("dsf_motion_state widths too small");
  end

  typedef struct packed {
    logic [SPEED_W:0] prevSetMag;
    logic [7:0]       flags;
  } dsf_motion_t;

  dsf_motion_t state_reg;
  dsf_motion_t state_next;

  // magnitudes carry one extra bit so the most negative value fits
  logic [SPEED_W:0] actMag;
  logic [SPEED_W:0] setMag;
  logic [POS_W:0]   devMag;

  always_comb begin
    actMag = actualSpeed[SPEED_W-1] ? -(SPEED_W+1)'(actualSpeed) : (SPEED_W+1)'(actualSpeed);
    setMag = setpointSpeed[SPEED_W-1] ? -(SPEED_W+1)'(setpointSpeed)
                                      : (SPEED_W+1)'(setpointSpeed);
    devMag = positionDeviation[POS_W-1] ? -(POS_W+1)'(positionDeviation)
                                        : (POS_W+1)'(positionDeviation);
    state_next            = state_reg;
    state_next.prevSetMag = setMag;
    state_next.flags[0] = actMag < (SPEED_W+1)'(dsf_pkg::STOP_SPEED_RPM);
    state_next.flags[1] = !actualSpeed[SPEED_W-1] && (actualSpeed != '0);
    state_next.flags[2] = actualSpeed[SPEED_W-1];
    state_next.flags[3] = devMag <= {1'b0, positionWindow};
    state_next.flags[4] = (setMag == '0);
    state_next.flags[5] = (setMag != '0) && (setMag < state_reg.prevSetMag);
    state_next.flags[6] = (setMag != '0) && (setMag > state_reg.prevSetMag);
    state_next.flags[7] = (setMag != '0) && (setMag == state_reg.prevSetMag);
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign driveStopped     = state_reg.flags[0];
  assign rotatePositive   = state_reg.flags[1];
  assign rotateNegative   = state_reg.flags[2];
  assign inPositionWindow = state_reg.flags[3];
  assign pgStopped        = state_reg.flags[4];
  assign pgDecel          = state_reg.flags[5];
  assign pgAccel          = state_reg.flags[6];
  assign pgConstant       = state_reg.flags[7];

endmodule : dsf_motion_state

/* File: dsf_monitor.sv */
// concurrent checks on the ports of the status and fault response bank
`timescale 1ns/1ps
module dsf_monitor #(
  parameter int SPEED_W = 16
) (
  input wire logic                      mclk,
  input wire logic                      rst_b,
  input wire logic        [15:0]        regAddr,
  input wire logic                      regWrite,
  input wire logic                      regRead,
  input wire logic        [15:0]        regWdata,
  input wire logic                      regAck,
  input wire logic                      regErr,
  input wire logic                      faultClearCmd,
  input wire logic                      ampTempHigh,
  input wire logic                      positionInvalid,
  input wire logic                      trackingErrorEvent,
  input wire logic signed [SPEED_W-1:0] actualSpeed,
  input wire logic        [15:0]        latchedWarnings,
  input wire logic        [15:0]        actionWord,
  input wire logic        [15:0]        lastStopFaultNumber,
  input wire logic                      reactionStrobe
);
  default clocking dcb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // motion flags lag the speed by two flops, so three steady samples are needed
  sequence spdStill; (actualSpeed == '0) [*3]; endsequence
  sequence spdFwd; (actualSpeed > 16'sh0009) [*3]; endsequence
  a_one_answer: assert property ((regWrite || regRead) |=> (regAck != regErr))
    else $error("access not answered once");
  a_bad_class: assert property (regWrite && regAddr == dsf_pkg::ADDR_TRACK_RESP
    && (regWdata < dsf_pkg::RESP_CLASS_MIN || regWdata > dsf_pkg::RESP_CLASS_MAX) |=> regErr)
    else $error("illegal class accepted");
  a_rsvd_zero: assert property ((latchedWarnings & dsf_pkg::WARN_RSVD_MASK) == '0
    && (actionWord & 16'h8420) == '0) else $error("reserved bit set");
  a_warn_clear: assert property (faultClearCmd && !ampTempHigh |=> !latchedWarnings[1])
    else $error("warning survived clear");
  a_auto_follow: assert property (1'b1 |=> latchedWarnings[13] == $past(positionInvalid))
    else $error("position warning not following cause");
  a_track_stop: assert property (trackingErrorEvent |=> reactionStrobe
    && lastStopFaultNumber == dsf_pkg::FAULT_NUM_TRACKING) else $error("tracking not recorded");
  a_stop_flag: assert property (spdStill |-> actionWord[6])
    else $error("stopped flag missing");
  a_dir_pos: assert property (spdFwd |-> actionWord[7] && !actionWord[8] && !actionWord[6])
    else $error("direction flags wrong");
endmodule : dsf_monitor
bind drive_status_fault_response_regs dsf_monitor #(.SPEED_W(SPEED_W)) u_mon (.mclk, .rst_b,
  .regAddr, .regWrite, .regRead, .regWdata, .regAck, .regErr, .faultClearCmd, .ampTempHigh,
  .positionInvalid, .trackingErrorEvent, .actualSpeed, .latchedWarnings, .actionWord,
  .lastStopFaultNumber, .reactionStrobe);

/* File: dsf_bus_master.sv */
// parameter access master standing where the fieldbus or panel would be
`timescale 1ns/1ps
module dsf_bus_master (
  input  wire logic        mclk,
  output logic      [15:0] regAddr,
  output logic             regWrite,
  output logic             regRead,
  output logic      [15:0] regWdata
);
  initial begin
    {regAddr, regWrite, regRead, regWdata} = '0;
  end
  // class values passed on unchanged; one-cycle request, answer next edge
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk);
    #1;
    {regAddr, regWdata, regWrite, regRead} = {a, d, wr, !wr};
    @(posedge mclk);
    #1;
    // released lines show the inverse so a stale value cannot pass
    {regAddr, regWdata, regWrite, regRead} = {~a, ~d, 2'h0};
    @(posedge mclk);
    #1;
  endtask : xfer
endmodule : dsf_bus_master

/* File: tb_top.sv */
// self-checking bench for the drive status and fault response bank
`timescale 1ns/1ps
module tb_top;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] regAddr, regWdata, regRdata, generalWarnCode, faultNumber, latchedWarnings;
  logic [15:0] actionWord, lastStopFaultNumber, lastWarningCode, v, ex;
  logic regWrite, regRead, regAck, regErr, faultClearCmd, generalWarn, ampTempHigh;
  logic motorTempHigh, ampOverload, motorOverload, brakeOverload, canWarn, encoderWarn;
  logic rs485Warn, fieldbusWarn, dcUndervoltage, phaseFault, positionInvalid, faultEvent;
  logic powerRemovalInputA_b, powerRemovalInputB_b, trackingErrorEvent, phaseLossEvent;
  logic reactionStrobe;
  logic [1:0] controlMode, reactionClass;
  logic [2:0] faultClass;
  logic signed [15:0] actualSpeed, setpointSpeed;
  logic signed [31:0] positionDeviation;
  logic [31:0] positionWindow, r;
  int n_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  typedef struct {logic rd; logic err; logic [15:0] d;} dsf_note_t;
  dsf_note_t q[$];
  dsf_note_t nt;
  always #10 mclk = ~mclk;
  dsf_bus_master master (.mclk, .regAddr, .regWrite, .regRead, .regWdata);
  drive_status_fault_response_regs dut (.mclk, .rst_b, .regAddr, .regWrite, .regRead, .regWdata,
    .regRdata, .regAck, .regErr, .faultClearCmd, .controlMode, .generalWarn, .generalWarnCode,
    .ampTempHigh, .motorTempHigh, .ampOverload, .motorOverload, .brakeOverload, .canWarn,
    .encoderWarn, .rs485Warn, .fieldbusWarn, .dcUndervoltage, .phaseFault, .positionInvalid,
    .powerRemovalInputA_b, .powerRemovalInputB_b, .trackingErrorEvent, .phaseLossEvent,
    .faultEvent, .faultClass, .faultNumber, .actualSpeed, .setpointSpeed, .positionDeviation,
    .positionWindow, .latchedWarnings, .actionWord, .lastStopFaultNumber, .lastWarningCode,
    .reactionClass, .reactionStrobe);
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    comparisons++;
    if (got !== want) begin
      n_errors++;
      $display("MISMATCH %0t got %h want %h", $time, got, want);
    end
  endtask : chk
  // note the expected answer first, then let the master run the access
  task automatic acc(input logic wr, input logic [15:0] a, input logic e, input logic [15:0] x);
    q.push_back('{!wr, e, x});
    master.xfer(wr, a, x);
  endtask : acc
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic setc(input logic [9:0] c);
    {fieldbusWarn, rs485Warn, encoderWarn, canWarn, brakeOverload, motorOverload, ampOverload,
     motorTempHigh, ampTempHigh, generalWarn} = c;
  endtask : setc
  task automatic stop_test;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  // answers are judged against the oldest note once settled, mid-cycle
  always @(negedge mclk) begin
    if (regAck === 1'b1 || regErr === 1'b1) begin
      nt = q.pop_front();
      chk({15'h0, regErr}, {15'h0, nt.err});
      if (nt.rd) chk(regRdata, nt.d);
    end
  end
  // a hang is cut short long after the last scenario should be over
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    {faultClearCmd, dcUndervoltage, phaseFault, positionInvalid, faultEvent} = '0;
    {trackingErrorEvent, phaseLossEvent, generalWarnCode, faultNumber, faultClass} = '0;
    {powerRemovalInputA_b, powerRemovalInputB_b, controlMode} = 4'hC;
    {actualSpeed, setpointSpeed, positionDeviation, positionWindow} = '0;
    setc(10'h000);
    void'($urandom(56));
    tick(6);
    rst_b = 1'b1;
    // defaults, refused classes at both ends, random legal class, read-only and unmapped
    acc(1'b0, dsf_pkg::ADDR_PHASE_LOSS_RESP, 1'b0, dsf_pkg::RST_PHASE_LOSS_RESP);
    acc(1'b0, dsf_pkg::ADDR_TRACK_RESP, 1'b0, dsf_pkg::RST_TRACK_RESP);
    v = 16'($urandom_range(3, 1));
    acc(1'b1, dsf_pkg::ADDR_PHASE_LOSS_RESP, 1'b0, v);
    acc(1'b1, dsf_pkg::ADDR_PHASE_LOSS_RESP, 1'b1, 16'h0004);
    acc(1'b1, dsf_pkg::ADDR_TRACK_RESP, 1'b1, 16'h0000);
    acc(1'b1, dsf_pkg::ADDR_TRACK_RESP, 1'b0, 16'h0001);
    acc(1'b0, dsf_pkg::ADDR_PHASE_LOSS_RESP, 1'b0, v);
    acc(1'b1, dsf_pkg::ADDR_STOP_FAULT, 1'b1, 16'h0001);
    acc(1'b0, 16'h0000, 1'b1, 16'h0000);
    // random one-cycle causes latch under fieldbus control, then a clear
    r = $urandom | 32'h0000_0003;
    controlMode = dsf_pkg::CTRL_FIELDBUS;
    setc(r[9:0]);
    generalWarnCode = r[31:16];
    tick(1);
    setc(10'h000);
    acc(1'b0, dsf_pkg::ADDR_LATCHED_WARN, 1'b0, {3'h0, r[9], 2'h0, r[8:3], 1'b0, r[2:0]});
    chk(lastWarningCode, r[31:16]);
    faultClearCmd = 1'b1;
    tick(1);
    faultClearCmd = 1'b0;
    acc(1'b0, dsf_pkg::ADDR_LATCHED_WARN, 1'b0, 16'h0000);
    controlMode = dsf_pkg::CTRL_IO;
    setc(10'h240);
    tick(1);
    setc(10'h000);
    acc(1'b0, dsf_pkg::ADDR_LATCHED_WARN, 1'b0, 16'h0000);
    // self-clearing bits follow their causes without a clear
    {dcUndervoltage, positionInvalid, powerRemovalInputA_b} = 3'h6;
    tick(5);
    acc(1'b0, dsf_pkg::ADDR_LATCHED_WARN, 1'b0, dsf_pkg::WARN_AUTO_MASK);
    {dcUndervoltage, positionInvalid, powerRemovalInputA_b} = 3'h1;
    tick(5);
    acc(1'b0, dsf_pkg::ADDR_LATCHED_WARN, 1'b0, 16'h0000);
    // fault reactions use the written classes; class bits held until cleared
    trackingErrorEvent = 1'b1;
    tick(1);
    trackingErrorEvent = 1'b0;
    chk({14'h0, reactionClass}, 16'h0001);
    {phaseLossEvent, faultEvent, faultClass} = 5'h1C;
    tick(1);
    {phaseLossEvent, faultEvent} = 2'h0;
    chk({14'h0, reactionClass}, v);
    acc(1'b0, dsf_pkg::ADDR_STOP_FAULT, 1'b0, dsf_pkg::FAULT_NUM_PHASELOSS);
    ex = 16'h0012;
    ex[v[1:0]] = 1'b1;
    chk(actionWord & 16'h001F, ex);
    faultClearCmd = 1'b1;
    tick(1);
    faultClearCmd = 1'b0;
    tick(2);
    chk(actionWord & 16'h001F, 16'h0000);
    // reverse rotation with a rising setpoint, then forward, then standstill
    actualSpeed = -16'sh0064;
    positionDeviation = -32'sh0000_0005;
    for (int i = 0; i < 4; i++) begin
      setpointSpeed = setpointSpeed + 16'sh0001;
      tick(1);
    end
    chk(actionWord & 16'h7BC0, 16'h2100);
    actualSpeed = 16'($urandom_range(900, 10));
    tick(4);
    {actualSpeed, setpointSpeed} = '0;
    positionWindow = 32'h0000_0005;
    tick(4);
    chk(actionWord & 16'h7BC0, 16'h0A40);
    stop_test();
  end
endmodule : tb_top
